// file: hdl/wsg_defs.svh
`ifndef WSG_DEFS_SVH
`define WSG_DEFS_SVH

// number of wait count registers: three memory, three io
`define WSG_NUM_REGS    6
// reset value of every wait count register (all ones)
`define WSG_CNT_RST     4'hF
// select code that turns the generator off
`define WSG_SEL_OFF     2'h3
// register index of the first io wait count register
`define WSG_IDX_IO_BASE 3'h3
// extra wait state added to non-pipelined cycles
`define WSG_NP_EXTRA    5'h01

`endif

// file: hdl/wsg_pkg.sv
package wsg_pkg;

  // programmed wait count, 0 to 15
  typedef logic [3:0] wsg_cnt_t;
  // wait states left in a cycle, 0 to 16
  typedef logic [4:0] wsg_wait_t;
  // register index 0 to 5
  typedef logic [2:0] wsg_idx_t;

  // bus state as seen by the tracker
  typedef enum logic [1:0] {
    WSG_IDLE,
    WSG_T1,
    WSG_T2
  } wsg_bus_e;

endpackage : wsg_pkg

// file: hdl/wsg_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface wsg_cfg_if;
  import wsg_pkg::*;

  logic     wr_en;   // write strobe for one wait count register
  wsg_idx_t wr_idx;  // register index being written
  wsg_cnt_t wr_data; // new wait count
  logic     mio;     // captured cycle type, 1 = memory
  logic [1:0] sel;   // captured select code
  wsg_cnt_t count;   // wait count of the selected register

  modport regs (
    input  wr_en,
    input  wr_idx,
    input  wr_data,
    input  mio,
    input  sel,
    output count
  );

  modport user (
    output wr_en,
    output wr_idx,
    output wr_data,
    output mio,
    output sel,
    input  count
  );

endinterface : wsg_cfg_if

`default_nettype wire

// file: hdl/wsg_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "wsg_defs.svh"

module wsg_regs
  import wsg_pkg::*;
(
  input wire logic core_clk, // system bus clock
  input wire logic rstn,     // asynchronous reset, active low
  wsg_cfg_if.regs  cfg       // register write and lookup
);

  wsg_cnt_t cnt_mem [`WSG_NUM_REGS];
  wsg_cnt_t next_cnt_mem [`WSG_NUM_REGS];

  // memory cycles use indices 0..2, io cycles 3..5
  function automatic wsg_idx_t wsg_index(input logic       mio,
                                         input logic [1:0] sel);
    wsg_idx_t base;
    base = mio ? 3'h0 : `WSG_IDX_IO_BASE;
    return 3'(base + {1'b0, sel});
  endfunction : wsg_index

  always_comb begin
    for (int i = 0; i < `WSG_NUM_REGS; i++) begin
      next_cnt_mem[i] = cnt_mem[i];
    end
    if (cfg.wr_en && (cfg.wr_idx < 3'(`WSG_NUM_REGS))) begin
      next_cnt_mem[cfg.wr_idx] = cfg.wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `WSG_NUM_REGS; i++) begin
        cnt_mem[i] <= `WSG_CNT_RST;
      end
    end else begin
      for (int i = 0; i < `WSG_NUM_REGS; i++) begin
        cnt_mem[i] <= next_cnt_mem[i];
      end
    end
  end

  // select code 3 never reaches here as a live choice; index 3/6 harmless
  always_comb begin
    wsg_idx_t idx;
    idx = wsg_index(cfg.mio, cfg.sel);
    if (idx < 3'(`WSG_NUM_REGS)) begin
      cfg.count = cnt_mem[idx];
    end else begin
      cfg.count = 4'h0;
    end
  end

endmodule : wsg_regs

`default_nettype wire

// file: hdl/wsg_top.sv
// Notes on behaviour
// - select code plus cycle type picks register
// - hold ready inactive for chosen count
// - counts range zero to fifteen
// - select both high: generator stays off, ready never driven
// - track bus state on every cycle
// - pipelined cycle: exactly programmed wait states
// - non-pipelined cycle: one extra wait state
// - reset loads all ones into registers
// - classify cycles from strobe and ready
`timescale 1ns/1ps
`default_nettype none
`include "wsg_defs.svh"

module wsg_top
  import wsg_pkg::*;
(
  input  wire logic       core_clk,                  // bus clock, 100 MHz
  input  wire logic       rstn,                      // async reset, low
  input  wire logic       bus_cycle_address_strobe_n, // address strobe pin
  input  wire logic       ready_n_i,                 // ready pin level
  input  wire logic       mio_i,                     // 1 memory, 0 io
  input  wire logic [1:0] wsel_i,                    // wait select pins
  input  wire logic       cfg_we,                    // wait count write
  input  wire logic [2:0] cfg_idx,                   // register index 0..5
  input  wire logic [3:0] cfg_data,                  // wait count value
  output logic            ready_o,                   // ready drive level
  output logic            ready_oe,                  // ready drive enable
  output logic            cycle_pipelined,           // current cycle kind
  output logic            cycle_active               // generator counting
);

  wsg_cfg_if cfg ();

  // pin synchronisers; stage one only feeds stage two
  logic       ads_m;
  logic       ads_s;
  logic       rdy_m;
  logic       rdy_s;
  logic       mio_m;
  logic       mio_s;
  logic [1:0] sel_m;
  logic [1:0] sel_s;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ads_m <= 1'b1;
      ads_s <= 1'b1;
      rdy_m <= 1'b1;
      rdy_s <= 1'b1;
      mio_m <= 1'b0;
      mio_s <= 1'b0;
      sel_m <= `WSG_SEL_OFF;
      sel_s <= `WSG_SEL_OFF;
    end else begin
      ads_m <= bus_cycle_address_strobe_n;
      ads_s <= ads_m;
      rdy_m <= ready_n_i;
      rdy_s <= rdy_m;
      mio_m <= mio_i;
      mio_s <= mio_m;
      sel_m <= wsel_i;
      sel_s <= sel_m;
    end
  end

  logic ads_seen;
  logic rdy_seen;
  // our own pull comes back through the synchroniser two clocks later and
  // must not end the following pipelined cycle; an outside ready landing
  // exactly on that echo is lost
  logic echo_m;
  logic echo_s;
  assign ads_seen = !ads_s;
  assign rdy_seen = !rdy_s && !echo_s;

  // tracker state
  wsg_bus_e  state;
  wsg_bus_e  next_state;
  wsg_wait_t cnt;
  wsg_wait_t next_cnt;
  logic      act;
  logic      next_act;
  logic      pipe;
  logic      next_pipe;
  logic      drive;
  logic      next_drive;
  // a pipelined strobe seen before the running cycle ended
  logic       pend;
  logic       next_pend;
  logic       pend_mio;
  logic       next_pend_mio;
  logic [1:0] pend_sel;
  logic [1:0] next_pend_sel;
  // select captured for the cycle whose count is being loaded
  logic       cap_mio;
  logic       next_cap_mio;
  logic [1:0] cap_sel;
  logic [1:0] next_cap_sel;
  logic       load;
  logic       load_pipe;

  assign cfg.wr_en   = cfg_we;
  assign cfg.wr_idx  = cfg_idx;
  assign cfg.wr_data = cfg_data;
  // lookup is addressed by the select being captured in this clock
  assign cfg.mio     = next_cap_mio;
  assign cfg.sel     = next_cap_sel;

  wsg_regs u_regs (
    .core_clk (core_clk),
    .rstn     (rstn),
    .cfg      (cfg.regs)
  );

  // wait states to load for a cycle of the given kind
  function automatic wsg_wait_t wsg_waits(input wsg_cnt_t c,
                                          input logic     piped);
    wsg_wait_t w;
    w = {1'b0, c};
    if (!piped) begin
      w = 5'(w + `WSG_NP_EXTRA);
    end
    return w;
  endfunction : wsg_waits

  // the cycle ends on the bus ready or on our own drive; our own drive
  // is counted directly since the pin copy returns two clocks late
  logic done;
  assign done = (state == WSG_T2) && (drive || rdy_seen);

  always_comb begin
    next_state    = state;
    next_pend     = pend;
    next_pend_mio = pend_mio;
    next_pend_sel = pend_sel;
    next_cap_mio  = cap_mio;
    next_cap_sel  = cap_sel;
    next_pipe     = pipe;
    load          = 1'b0;
    load_pipe     = 1'b0;
    unique case (state)
      WSG_IDLE: begin
        if (ads_seen) begin
          next_state   = WSG_T1;
          next_cap_mio = mio_s;
          next_cap_sel = sel_s;
          load         = 1'b1;
          load_pipe    = 1'b0;
        end
      end
      WSG_T1: begin
        next_state = WSG_T2;
      end
      WSG_T2: begin
        if (done) begin
          if (pend) begin
            next_state   = WSG_T2;
            next_cap_mio = pend_mio;
            next_cap_sel = pend_sel;
            next_pend    = 1'b0;
            load         = 1'b1;
            load_pipe    = 1'b1;
          end else if (ads_seen) begin
            // strobe coinciding with ready: next cycle is pipelined
            next_state   = WSG_T2;
            next_cap_mio = mio_s;
            next_cap_sel = sel_s;
            load         = 1'b1;
            load_pipe    = 1'b1;
          end else begin
            next_state = WSG_IDLE;
          end
        end else if (ads_seen && !pend) begin
          // strobe while this cycle still waits: remember it
          next_pend     = 1'b1;
          next_pend_mio = mio_s;
          next_pend_sel = sel_s;
        end
      end
    endcase
    if (load) begin
      next_pipe = load_pipe;
    end
  end

  // the count is loaded in the clock of the capture, so a pipelined cycle
  // already knows its waits when its predecessor ends
  always_comb begin
    next_cnt    = cnt;
    next_act    = act;
    if (load) begin
      next_act = (next_cap_sel != `WSG_SEL_OFF);
      next_cnt = wsg_waits(cfg.count, load_pipe);
    end else if ((state == WSG_T2) && !done && (cnt != 5'h00)) begin
      next_cnt = 5'(cnt - 5'h01);
    end
    if (done && !load) begin
      next_act = 1'b0;
    end
  end

  // drive ready low in the T2 state where no waits are left
  always_comb begin
    next_drive = 1'b0;
    // a pipelined cycle with no waits answers right after its predecessor
    if ((next_state == WSG_T2) && next_act) begin
      next_drive = (next_cnt == 5'h00) && (load || !done);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state    <= WSG_IDLE;
      cnt      <= 5'h00;
      act      <= 1'b0;
      pipe     <= 1'b0;
      drive    <= 1'b0;
      pend     <= 1'b0;
      pend_mio <= 1'b0;
      pend_sel <= `WSG_SEL_OFF;
      cap_mio  <= 1'b0;
      cap_sel  <= `WSG_SEL_OFF;
      echo_m   <= 1'b0;
      echo_s   <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      act      <= next_act;
      pipe     <= next_pipe;
      drive    <= next_drive;
      pend     <= next_pend;
      pend_mio <= next_pend_mio;
      pend_sel <= next_pend_sel;
      cap_mio  <= next_cap_mio;
      cap_sel  <= next_cap_sel;
      echo_m   <= drive;
      echo_s   <= echo_m;
    end
  end

  // open-drain style: only ever pull ready low, never drive it high
  assign ready_o         = 1'b0;
  assign ready_oe        = drive;
  assign cycle_pipelined = pipe;
  assign cycle_active    = act;

endmodule : wsg_top

`default_nettype wire

// file: testbench/wsg_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wsg_top_asserts (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       bus_cycle_address_strobe_n,
  input wire logic       ready_n_i,
  input wire logic       mio_i,
  input wire logic [1:0] wsel_i,
  input wire logic       cfg_we,
  input wire logic [2:0] cfg_idx,
  input wire logic [3:0] cfg_data,
  input wire logic       ready_o,
  input wire logic       ready_oe,
  input wire logic       cycle_pipelined,
  input wire logic       cycle_active
);
  logic [5:0] off_cnt;
  logic [4:0] wait_cnt;
  logic [3:0] strb_age;
  // ages saturate so a long quiet stretch never wraps round to zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      off_cnt  <= 6'h00;
      wait_cnt <= 5'h00;
      strb_age <= 4'hF;
    end else begin
      off_cnt  <= (wsel_i != 2'h3) ? 6'h00 : off_cnt + {5'h00, ~&off_cnt};
      wait_cnt <= (ready_oe || !cycle_active) ? 5'h00
                  : wait_cnt + {4'h0, ~&wait_cnt};
      strb_age <= !bus_cycle_address_strobe_n ? 4'h0
                  : strb_age + {3'h0, ~&strb_age};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_pull_low: assert property (ready_oe |-> !ready_o)
    else $error("ready driven high");
  a_one_pulse: assert property (ready_oe ##1 ready_oe |-> cycle_pipelined)
    else $error("ready pulse too long");
  a_oe_counting: assert property ($rose(ready_oe) |-> $past(cycle_active))
    else $error("ready without counting");
  a_off_quiet: assert property (&off_cnt |-> !ready_oe && !cycle_active)
    else $error("generator active while deselected");
  a_wait_bound: assert property (wait_cnt <= 5'd22)
    else $error("wait count overran");
  a_min_wait: assert property ($fell(bus_cycle_address_strobe_n)
    && !cycle_active |-> !ready_oe[*4]) else $error("ready too early");
  a_np_kind: assert property ($fell(cycle_pipelined) |-> strb_age < 4'h8)
    else $error("cycle kind changed without strobe");
  // checked through reset itself, so the usual disable is switched off
  a_reset_idle: assert property (disable iff (1'b0)
    !rstn |-> !ready_oe && !cycle_active && !cycle_pipelined)
    else $error("outputs busy in reset");
endmodule : wsg_top_asserts
`default_nettype wire

// file: testbench/wsg_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module wsg_bus_model (
  input  wire logic       core_clk, // bus clock
  output logic            strobe_n, // address strobe
  output logic            mio,      // 1 memory
  output logic [1:0]      wsel,     // peripheral select code
  output logic            rdy_n     // peripheral's own ready
);
  initial begin
    strobe_n = 1'b1;
    mio = 1'b1;
    wsel = 2'h0;
    rdy_n = 1'b1;
  end
  // select stays put until the next cycle, so the sampled code is stable
  task automatic start(input logic m, input logic [1:0] s);
    @(posedge core_clk);
    #1;
    strobe_n = 1'b0;
    mio = m;
    wsel = s;
    @(posedge core_clk);
    #1;
    strobe_n = 1'b1;
  endtask : start
  task automatic ext_ready;
    @(posedge core_clk);
    #1;
    rdy_n = 1'b0;
    @(posedge core_clk);
    #1;
    rdy_n = 1'b1;
  endtask : ext_ready
endmodule : wsg_bus_model
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       core_clk, rstn, cfg_we, ready_o, ready_oe;
  logic       cycle_pipelined, cycle_active, strobe_n, mio, rdy_n;
  logic       ready_pin, busy, pend;
  logic [1:0] wsel;
  logic [2:0] cfg_idx;
  logic [3:0] cfg_data;
  logic [3:0] cnt [6];
  logic [4:0] lat;
  logic [7:0] exp_q [$];
  int         err_total, n_tests, oe_n, oe0;
  // open-drain ready with pull-up
  assign ready_pin = !((ready_oe && !ready_o) || !rdy_n);
  wsg_bus_model bus (.core_clk, .strobe_n, .mio, .wsel, .rdy_n);
  wsg_top dut (.core_clk, .rstn, .bus_cycle_address_strobe_n(strobe_n),
    .ready_n_i(ready_pin), .mio_i(mio), .wsel_i(wsel), .cfg_we, .cfg_idx,
    .cfg_data, .ready_o, .ready_oe, .cycle_pipelined, .cycle_active);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [2:0] i, input logic [3:0] d);
    @(posedge core_clk);
    #1;
    cfg_we = 1'b1;
    cfg_idx = i;
    cfg_data = d;
    @(posedge core_clk);
    #1;
    cfg_we = 1'b0;
  endtask : wr
  task automatic drain;
    int k;
    k = 0;
    while ((exp_q.size() != 0 || busy) && k < 80) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 80) begin
      err_total++;
      test_done();
    end
    repeat (2) @(posedge core_clk);
  endtask : drain
  // latency counts from the strobe, or from the previous ready when piped
  always @(posedge core_clk) begin
    lat = lat + 5'h01;
    if (ready_oe === 1'b1) begin
      oe_n++;
      if (exp_q.size() == 0) chk(8'hFF, 8'h00);
      else chk({3'h0, lat}, exp_q.pop_front());
      lat = 5'h00;
      busy = pend;
      pend = 1'b0;
    end
    if (rdy_n === 1'b0) begin
      busy = pend;
      pend = 1'b0;
    end
    if (strobe_n === 1'b0) begin
      if (busy) pend = 1'b1;
      else begin
        busy = 1'b1;
        lat = 5'h00;
      end
    end
  end
  initial begin
    {rstn, cfg_we, cfg_idx, cfg_data, busy, pend, lat} = '0;
    {err_total, n_tests, oe_n} = '0;
    void'($urandom(41749));
    repeat (3) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    wr(3'h6, 4'h0);
    wr(3'h7, 4'h0);
    for (int i = 0; i < 6; i++) begin
      exp_q.push_back(8'd20);
      bus.start(i < 3, 2'(i % 3));
      drain();
    end
    $display("test reset_counts done");
    for (int i = 0; i < 6; i++) begin
      cnt[i] = (i == 0) ? 4'h0 : (i == 5) ? 4'hF : 4'($urandom % 16);
      wr(3'(i), cnt[i]);
    end
    for (int i = 0; i < 6; i++) begin
      exp_q.push_back(8'd5 + cnt[i]);
      bus.start(i < 3, 2'(i % 3));
      drain();
    end
    $display("test select_table done");
    oe0 = oe_n;
    bus.start(1'b0, 2'h3);
    repeat (64) @(posedge core_clk);
    chk(cycle_active, 1'b0);
    bus.ext_ready();
    repeat (4) @(posedge core_clk);
    chk(oe_n, oe0);
    exp_q.push_back(8'd5 + cnt[0]);
    bus.start(1'b1, 2'h0);
    drain();
    chk(cycle_pipelined, 1'b0);
    $display("test deselect done");
    wr(3'h2, 4'h9);
    exp_q.push_back(8'd14);
    exp_q.push_back(8'd1 + cnt[0]);
    bus.start(1'b1, 2'h2);
    repeat (2) @(posedge core_clk);
    bus.start(1'b1, 2'h0);
    drain();
    chk(cycle_pipelined, 1'b1);
    $display("test pipelined done");
    test_done();
  end
endmodule : tb_top
bind wsg_top wsg_top_asserts u_chk (.core_clk, .rstn,
  .bus_cycle_address_strobe_n, .ready_n_i, .mio_i, .wsel_i, .cfg_we,
  .cfg_idx, .cfg_data, .ready_o, .ready_oe, .cycle_pipelined, .cycle_active);
`default_nettype wire
